// ==== core/lmx_regs.vh ====
// Register offsets, field positions, reset values and opcodes of the move/return executor.
`ifndef LMX_REGS_VH
`define LMX_REGS_VH
`define LMX_OFF_WREG 8'h00
`define LMX_OFF_BANK 8'h04
`define LMX_OFF_PCHI 8'h08
`define LMX_OFF_PTR0 8'h0C
`define LMX_OFF_PTR1 8'h10
`define LMX_OFF_PWRC 8'h14
`define LMX_OFF_INTC 8'h18
`define LMX_OFF_PC 8'h1C
`define LMX_OFF_FLAGS 8'h20
`define LMX_RST_WREG 8'h00
`define LMX_RST_BANK 6'h00
`define LMX_RST_PCHI 7'h00
`define LMX_RST_PTR 16'h0000
`define LMX_RST_PC 15'h0000
`define LMX_RST_FLAGS 8'h00
`define LMX_GIE_BIT 7
`define LMX_RI_BIT 2
`define LMX_RET_CYCLES 2
`define LMX_OP_NOP 14'h0000
`define LMX_OP_RESET 14'h0001
`define LMX_OP_RETI 14'h0009
`define LMX_MSK_WI 14'h3FF8
`define LMX_VAL_WI 14'h0018
`define LMX_MSK_WIK 14'h3F80
`define LMX_VAL_WIK 14'h3F80
`define LMX_MSK_WF 14'h3F80
`define LMX_VAL_WF 14'h0080
`define LMX_MSK_LB 14'h3FC0
`define LMX_VAL_LB 14'h0140
`define LMX_MSK_LP 14'h3F80
`define LMX_VAL_LP 14'h3180
`define LMX_MSK_LW 14'h3F00
`define LMX_VAL_LW 14'h3000
`define LMX_RESP_OK 2'h0
`define LMX_RESP_ERR 2'h2
`endif

// ==== core/lmx_ptr_unit.v ====
// Effective address and pointer update for the indirect store.
`timescale 1ns/1ps
`default_nettype none
module lmx_ptr_unit
(
   // Pointer and addressing form
   input wire [15:0] ptr,
   input wire [1:0] mode,
   input wire rel,
   input wire [5:0] offs,
   // Results
   output reg [15:0] ea,
   output reg [15:0] ptr_nxt
);
   // Sixteen-bit sums wrap by truncation, both ways.
   function [15:0] add16;
      input [15:0] a;
      input [15:0] b;
      begin
         add16 = a + b;
      end
   endfunction

   wire [15:0] offs_ext = {{10{offs[5]}}, offs};

   always @*
   begin
      ea = ptr;
      ptr_nxt = ptr;
      if (rel)
      begin
         ea = add16(ptr, offs_ext);
      end
      else
      begin
         case (mode)
            2'b00:
            begin
               ea = add16(ptr, 16'h0001);
               ptr_nxt = add16(ptr, 16'h0001);
            end
            2'b01:
            begin
               ea = add16(ptr, 16'hFFFF);
               ptr_nxt = add16(ptr, 16'hFFFF);
            end
            2'b10:
            begin
               ptr_nxt = add16(ptr, 16'h0001);
            end
            default:
            begin
               ptr_nxt = add16(ptr, 16'hFFFF);
            end
         endcase
      end
   end
endmodule // lmx_ptr_unit
`default_nettype wire

// ==== core/lmx_axil_slave.v ====
// AXI4-Lite slave front end: channel handshakes, one write and one read at a time.
`timescale 1ns/1ps
`default_nettype none
`include "lmx_regs.vh"
module lmx_axil_slave #(
   parameter AW = 8
)
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // AXI4-Lite
   input wire [AW-1:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [AW-1:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // Register file side
   output wire wr_en,
   output reg [AW-1:0] wr_addr,
   output reg [31:0] wr_data,
   output reg [3:0] wr_strb,
   input wire wr_ok,
   output wire [AW-1:0] rd_addr,
   input wire [31:0] rd_data,
   input wire rd_ok
);
   reg aw_held_r;
   reg w_held_r;

   assign awready = ~aw_held_r & ~bvalid;
   assign wready = ~w_held_r & ~bvalid;
   assign wr_en = aw_held_r & w_held_r & ~bvalid;
   assign arready = ~rvalid;
   assign rd_addr = araddr;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `LMX_RESP_OK;
         wr_addr <= {AW{1'b0}};
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
         rvalid <= 1'b0;
         rresp <= `LMX_RESP_OK;
         rdata <= 32'h0000_0000;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_held_r <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_held_r <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_en)
         begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok ? `LMX_RESP_OK : `LMX_RESP_ERR;
         end
         else if (bvalid && bready)
         begin
            bvalid <= 1'b0;
         end
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= rd_ok ? rd_data : 32'h0000_0000;
            rresp <= rd_ok ? `LMX_RESP_OK : `LMX_RESP_ERR;
         end
         else if (rvalid && rready)
         begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule // lmx_axil_slave
`default_nettype wire

// ==== core/lmx_exec.v ====
// Executor for literal moves, file and indirect stores, no-op, software reset and return.
`timescale 1ns/1ps
`default_nettype none
`include "lmx_regs.vh"

module lmx_exec #(
   parameter AW = 8,
   parameter PC_W = 15
)
(
   // Clock and reset
   input wire SYS_CLK,
   input wire RST_N,
   // Instruction stream
   input wire INSTR_VALID,
   input wire [13:0] INSTR_DATA,
   output wire INSTR_READY,
   // Hardware stack
   input wire [PC_W-1:0] STACK_TOP,
   output wire STACK_POP,
   // Core state
   output wire [PC_W-1:0] PC_OUT,
   output wire GIE_OUT,
   output wire DEV_RESET_REQ,
   // Data memory write
   output wire DATA_WE,
   output wire [15:0] DATA_ADDR,
   output wire [7:0] DATA_WDATA,
   // AXI4-Lite register bus
   input wire [AW-1:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output wire [1:0] S_AXI_BRESP,
   output wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [AW-1:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0] S_AXI_RRESP,
   output wire S_AXI_RVALID,
   input wire S_AXI_RREADY
);
   localparam [1:0] ST_RUN = 2'b01;
   localparam [1:0] ST_RET = 2'b10;

   reg [7:0] w_r;
   reg [5:0] bsr_r;
   reg [6:0] pc_high_latch_r;
   reg [15:0] fsr0_r;
   reg [15:0] fsr1_r;
   reg ri_r;
   reg gie_r;
   reg [7:0] flags_r;
   reg [PC_W-1:0] pc_r;
   reg [1:0] state_r;
   reg pop_r;
   reg devrst_r;
   reg dwe_r;
   reg [15:0] daddr_r;
   reg [7:0] dwdata_r;

   wire wr_en;
   wire [AW-1:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire [AW-1:0] rd_addr;
   reg [31:0] rd_data;
   reg rd_ok;
   wire [15:0] ea;
   wire [15:0] ptr_upd;

   // Byte-lane merge of a 16-bit register.
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge16 = old;
         if (strb[0])
            merge16[7:0] = data[7:0];
         if (strb[1])
            merge16[15:8] = data[15:8];
      end
   endfunction

   // Whether an offset names a register of this block.
   function addr_hit;
      input [AW-1:0] a;
      begin
         case (a)
            `LMX_OFF_WREG, `LMX_OFF_BANK, `LMX_OFF_PCHI, `LMX_OFF_PTR0, `LMX_OFF_PTR1,
            `LMX_OFF_PWRC, `LMX_OFF_INTC, `LMX_OFF_PC, `LMX_OFF_FLAGS:
               addr_hit = 1'b1;
            default:
               addr_hit = 1'b0;
         endcase
      end
   endfunction

   // Instruction decode.
   wire [13:0] op = INSTR_DATA;
   wire take = INSTR_VALID & INSTR_READY;
   wire is_nop = (op == `LMX_OP_NOP);
   wire is_rst = (op == `LMX_OP_RESET);
   wire is_reti = (op == `LMX_OP_RETI);
   wire is_wi = ((op & `LMX_MSK_WI) == `LMX_VAL_WI);
   wire is_wik = ((op & `LMX_MSK_WIK) == `LMX_VAL_WIK);
   wire is_wf = ((op & `LMX_MSK_WF) == `LMX_VAL_WF);
   wire is_lb = ((op & `LMX_MSK_LB) == `LMX_VAL_LB);
   wire is_lp = ((op & `LMX_MSK_LP) == `LMX_VAL_LP);
   wire is_lw = ((op & `LMX_MSK_LW) == `LMX_VAL_LW);
   // File addresses 0 and 1 are the two indirect windows.
   wire wf_win = is_wf & (op[6:1] == 6'h00);
   wire ind_sel = is_wi ? op[2] : (is_wik ? op[6] : op[0]);
   wire [15:0] ind_ptr = ind_sel ? fsr1_r : fsr0_r;
   wire [PC_W-1:0] pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};

   lmx_ptr_unit u_ptr
   (
      .ptr(ind_ptr),
      .mode(op[1:0]),
      .rel(is_wik | wf_win),
      .offs(wf_win ? 6'h00 : op[5:0]),
      .ea(ea),
      .ptr_nxt(ptr_upd)
   );

   lmx_axil_slave #(
      .AW(AW)
   ) u_bus
   (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .awaddr(S_AXI_AWADDR),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .bresp(S_AXI_BRESP),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .araddr(S_AXI_ARADDR),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(addr_hit(wr_addr)),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // Read data comes from the live registers; the slave latches it at the address handshake.
   always @*
   begin
      rd_ok = addr_hit(rd_addr);
      rd_data = 32'h0000_0000;
      case (rd_addr)
         `LMX_OFF_WREG: rd_data[7:0] = w_r;
         `LMX_OFF_BANK: rd_data[5:0] = bsr_r;
         `LMX_OFF_PCHI: rd_data[6:0] = pc_high_latch_r;
         `LMX_OFF_PTR0: rd_data[15:0] = fsr0_r;
         `LMX_OFF_PTR1: rd_data[15:0] = fsr1_r;
         `LMX_OFF_PWRC: rd_data[`LMX_RI_BIT] = ri_r;
         `LMX_OFF_INTC: rd_data[`LMX_GIE_BIT] = gie_r;
         `LMX_OFF_PC: rd_data[PC_W-1:0] = pc_r;
         `LMX_OFF_FLAGS: rd_data[7:0] = flags_r;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // The second return cycle stalls the stream so the popped address is in place first.
   // one-cycle return stall
   assign INSTR_READY = state_r[1] ? 1'b0 : 1'b1;
   assign STACK_POP = pop_r;
   assign PC_OUT = pc_r;
   assign GIE_OUT = gie_r;
   assign DEV_RESET_REQ = devrst_r;
   assign DATA_WE = dwe_r;
   assign DATA_ADDR = daddr_r;
   assign DATA_WDATA = dwdata_r;

   always @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         w_r <= `LMX_RST_WREG;
         bsr_r <= `LMX_RST_BANK;
         pc_high_latch_r <= `LMX_RST_PCHI;
         fsr0_r <= `LMX_RST_PTR;
         fsr1_r <= `LMX_RST_PTR;
         // Set by a pin reset, cleared by the software reset and loaded from bit 2 by a bus write to PWRC, so the cause can be told.
         ri_r <= 1'b1;
         gie_r <= 1'b0;
         flags_r <= `LMX_RST_FLAGS;
         pc_r <= `LMX_RST_PC;
         state_r <= ST_RUN;
         pop_r <= 1'b0;
         devrst_r <= 1'b0;
         dwe_r <= 1'b0;
         daddr_r <= 16'h0000;
         dwdata_r <= 8'h00;
      end
      else
      begin
         pop_r <= 1'b0;
         devrst_r <= 1'b0;
         dwe_r <= 1'b0;
         // Software writes first, so an instruction in the same cycle overrides them.
         if (wr_en)
         begin
            case (wr_addr)
               `LMX_OFF_WREG: if (wr_strb[0]) w_r <= wr_data[7:0];
               `LMX_OFF_BANK: if (wr_strb[0]) bsr_r <= wr_data[5:0];
               `LMX_OFF_PCHI: if (wr_strb[0]) pc_high_latch_r <= wr_data[6:0];
               `LMX_OFF_PTR0: fsr0_r <= merge16(fsr0_r, wr_data, wr_strb);
               `LMX_OFF_PTR1: fsr1_r <= merge16(fsr1_r, wr_data, wr_strb);
               `LMX_OFF_PWRC: if (wr_strb[0]) ri_r <= wr_data[`LMX_RI_BIT];
               `LMX_OFF_INTC: if (wr_strb[0]) gie_r <= wr_data[`LMX_GIE_BIT];
               `LMX_OFF_FLAGS: if (wr_strb[0]) flags_r <= wr_data[7:0];
               // The program counter only follows the instruction stream; a bus write to it
               // is answered as a hit but dropped, so software cannot redirect execution.
               `LMX_OFF_PC: pc_r <= pc_r;
               default: w_r <= w_r;
            endcase
         end
         case (state_r)
            ST_RUN:
            begin
               if (take)
               begin
                  pc_r <= pc_inc;
                  if (is_lb)
                  begin
                     bsr_r <= op[5:0];
                  end
                  if (is_lp)
                  begin
                     pc_high_latch_r <= op[6:0];
                  end
                  if (is_lw)
                  begin
                     w_r <= op[7:0];
                  end
                  if (is_wf && !wf_win)
                  begin
                     dwe_r <= 1'b1;
                     daddr_r <= {3'h0, bsr_r, op[6:0]};
                     dwdata_r <= w_r;
                  end
                  if (wf_win || is_wi || is_wik)
                  begin
                     dwe_r <= 1'b1;
                     daddr_r <= ea;
                     dwdata_r <= w_r;
                  end
                  if (is_wi)
                  begin
                     if (ind_sel)
                        fsr1_r <= ptr_upd;
                     else
                        fsr0_r <= ptr_upd;
                  end
                  if (is_reti)
                  begin
                     pop_r <= 1'b1;
                     pc_r <= STACK_TOP;
                     gie_r <= 1'b1;
                     state_r <= ST_RET;
                  end
                  if (is_rst)
                  begin
                     devrst_r <= 1'b1;
                     ri_r <= 1'b0;
                     w_r <= `LMX_RST_WREG;
                     bsr_r <= `LMX_RST_BANK;
                     pc_high_latch_r <= `LMX_RST_PCHI;
                     fsr0_r <= `LMX_RST_PTR;
                     fsr1_r <= `LMX_RST_PTR;
                     gie_r <= 1'b0;
                     flags_r <= `LMX_RST_FLAGS;
                     pc_r <= `LMX_RST_PC;
                  end
               end
            end
            ST_RET:
            begin
               state_r <= ST_RUN;
            end
            default:
            begin
               state_r <= ST_RUN;
            end
         endcase
      end
   end

   // Opcodes outside this group are treated as one-cycle steps with no other effect.
   wire unused_nop = is_nop;
endmodule // lmx_exec
`default_nettype wire

// ==== sim/lmx_exec_asserts.sv ====
// Concurrent checks on the ports of the move and return executor.
`timescale 1ns/1ps
`default_nettype none
`include "lmx_regs.vh"
module lmx_exec_asserts #(
   parameter PC_W = 15
)
(
   // Clock and reset
   input wire SYS_CLK,
   input wire RST_N,
   // Instruction stream
   input wire INSTR_VALID,
   input wire [13:0] INSTR_DATA,
   input wire INSTR_READY,
   // Stack and core state
   input wire [PC_W-1:0] STACK_TOP,
   input wire STACK_POP,
   input wire [PC_W-1:0] PC_OUT,
   input wire GIE_OUT,
   input wire DEV_RESET_REQ,
   // Data memory write
   input wire DATA_WE,
   input wire [15:0] DATA_ADDR
);
   wire tk = INSTR_VALID & INSTR_READY;
   wire is_ret = tk & (INSTR_DATA == `LMX_OP_RETI);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   property p_ret_pop;
      is_ret |=> STACK_POP && !INSTR_READY ##1 INSTR_READY && !STACK_POP;
   endproperty
   a_ret_pop: assert property (p_ret_pop) else $error("return pop or stall wrong");
   property p_ret_pc;
      is_ret |=> PC_OUT == $past(STACK_TOP);
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("return did not load pc");
   property p_ret_gie;
      is_ret |=> GIE_OUT;
   endproperty
   a_ret_gie: assert property (p_ret_gie) else $error("return left enable clear");
   property p_rst_req;
      tk && INSTR_DATA == `LMX_OP_RESET |=> DEV_RESET_REQ ##1 !DEV_RESET_REQ;
   endproperty
   a_rst_req: assert property (p_rst_req) else $error("reset request pulse wrong");
   property p_nop;
      tk && INSTR_DATA == `LMX_OP_NOP |=> PC_OUT == $past(PC_OUT) + 1'b1 && !DATA_WE;
   endproperty
   a_nop: assert property (p_nop) else $error("no-op changed more than pc");
   property p_lw;
      tk && (INSTR_DATA & `LMX_MSK_LW) == `LMX_VAL_LW |=> PC_OUT == $past(PC_OUT) + 1'b1;
   endproperty
   a_lw: assert property (p_lw) else $error("literal load not one cycle");
   property p_wf;
      tk && (INSTR_DATA & `LMX_MSK_WF) == `LMX_VAL_WF && INSTR_DATA[6:1] != 6'h00
         |=> DATA_WE && DATA_ADDR[6:0] == $past(INSTR_DATA[6:0]) && DATA_ADDR[15:13] == 3'h0;
   endproperty
   a_wf: assert property (p_wf) else $error("file store address wrong");
   property p_wi;
      tk && (INSTR_DATA & `LMX_MSK_WI) == `LMX_VAL_WI |=> DATA_WE;
   endproperty
   a_wi: assert property (p_wi) else $error("indirect store wrote nothing");
   property p_wik;
      tk && (INSTR_DATA & `LMX_MSK_WIK) == `LMX_VAL_WIK |=> DATA_WE;
   endproperty
   a_wik: assert property (p_wik) else $error("offset store wrote nothing");
endmodule // lmx_exec_asserts

bind lmx_exec lmx_exec_asserts #(.PC_W(PC_W)) lmx_exec_asserts_i (.SYS_CLK(SYS_CLK),
   .RST_N(RST_N), .INSTR_VALID(INSTR_VALID), .INSTR_DATA(INSTR_DATA),
   .INSTR_READY(INSTR_READY), .STACK_TOP(STACK_TOP), .STACK_POP(STACK_POP), .PC_OUT(PC_OUT),
   .GIE_OUT(GIE_OUT), .DEV_RESET_REQ(DEV_RESET_REQ), .DATA_WE(DATA_WE), .DATA_ADDR(DATA_ADDR));
`default_nettype wire

// ==== sim/lmx_exec_tb_top.sv ====
// Self-checking bench for the move and return executor.
`timescale 1ns/1ps
`default_nettype none
`include "lmx_regs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module lmx_exec_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic iv = 1'b0;
   logic [13:0] id = 14'h0000;
   logic [14:0] stack_top = 15'h0000;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   wire irdy, pop, global_interrupt_enable, rreq, we, awready, wready, bvalid, arready, rvalid;
   wire [14:0] pc;
   wire [15:0] daddr;
   wire [7:0] wd;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int err_total = 0;
   int samples_checked = 0;

   always #10 clk = ~clk;

   lmx_exec #(.AW(8), .PC_W(15)) lmx_exec_i (.SYS_CLK(clk), .RST_N(rst_n), .INSTR_VALID(iv),
      .INSTR_DATA(id), .INSTR_READY(irdy), .STACK_TOP(stack_top), .STACK_POP(pop), .PC_OUT(pc),
      .GIE_OUT(global_interrupt_enable), .DEV_RESET_REQ(rreq), .DATA_WE(we), .DATA_ADDR(daddr), .DATA_WDATA(wd),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   // Handshakes are judged at the falling edge, since ready only moves after a rising edge.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw_t, w_t, b_t;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge clk);
         aw_t = awvalid & awready;
         w_t = wvalid & wready;
         b_t = bvalid & bready;
         r = bresp;
         @(posedge clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         n++;
      end
      while (!b_t && n < 50);
      bready <= 1'b0;
      if (!b_t) err_total++;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar_t, r_t;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge clk);
         ar_t = arvalid & arready;
         r_t = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_t) arvalid <= 1'b0;
         n++;
      end
      while (!r_t && n < 50);
      rready <= 1'b0;
      if (!r_t) err_total++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      `CHK("bresp", `LMX_RESP_OK, r)
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      `CHK("rresp", `LMX_RESP_OK, r)
      `CHK("register", e, d)
   endtask

   // Leaves the caller at the falling edge after the taking edge, where pulses stand.
   task automatic ins(input logic [13:0] op);
      int n;
      logic t;
      n = 0;
      @(posedge clk);
      iv <= 1'b1;
      id <= op;
      do
      begin
         @(negedge clk);
         t = irdy;
         @(posedge clk);
         n++;
      end
      while (!t && n < 50);
      iv <= 1'b0;
      if (!t) err_total++;
      @(negedge clk);
   endtask

   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      rchk(`LMX_OFF_WREG, 32'h0000_0000);
      rchk(`LMX_OFF_BANK, 32'h0000_0000);
      rchk(`LMX_OFF_PCHI, 32'h0000_0000);
      rchk(`LMX_OFF_PTR0, 32'h0000_0000);
      rchk(`LMX_OFF_PTR1, 32'h0000_0000);
      rchk(`LMX_OFF_PWRC, 32'h0000_0004);
      rchk(`LMX_OFF_INTC, 32'h0000_0000);
      rchk(`LMX_OFF_PC, 32'h0000_0000);
      axi_rd(8'h30, d, r);
      `CHK("unmapped rresp", `LMX_RESP_ERR, r)
      `CHK("unmapped rdata", 32'h0000_0000, d)
      axi_wr(8'h30, 32'h0000_0055, r);
      `CHK("unmapped bresp", `LMX_RESP_ERR, r)
      $display("reset values done");
   endtask

   task automatic t_literals;
      logic [14:0] p0;
      wr(`LMX_OFF_FLAGS, 32'h0000_00A5);
      p0 = pc;
      ins(`LMX_VAL_LW | 14'h00FF);
      rchk(`LMX_OFF_WREG, 32'h0000_00FF);
      ins(`LMX_VAL_LB | 14'h003F);
      rchk(`LMX_OFF_BANK, 32'h0000_003F);
      ins(`LMX_VAL_LP | 14'h007F);
      rchk(`LMX_OFF_PCHI, 32'h0000_007F);
      `CHK("pc", p0 + 15'h0003, pc)
      rchk(`LMX_OFF_FLAGS, 32'h0000_00A5);
      $display("literal loads done");
   endtask

   task automatic t_file_store;
      ins(`LMX_VAL_LB | 14'h0005);
      ins(`LMX_VAL_LW | 14'h004F);
      ins(`LMX_VAL_WF | 14'h007F);
      `CHK("we", 1'b1, we)
      `CHK("addr", 16'h02FF, daddr)
      `CHK("wdata", 8'h4F, wd)
      wr(`LMX_OFF_PTR1, 32'h0000_1234);
      ins(`LMX_VAL_WF | 14'h0001);
      `CHK("window addr", 16'h1234, daddr)
      rchk(`LMX_OFF_PTR1, 32'h0000_1234);
      $display("file store done");
   endtask

   // Start values sit at the wrap point so that every mode crosses it.
   task automatic t_indirect;
      logic [1:0] m;
      logic n;
      logic [15:0] p, ea, np;
      for (int k = 0; k < 8; k++)
      begin
         m = k[1:0];
         n = k[2];
         p = m[0] ? 16'h0000 : 16'hFFFF;
         wr(n ? `LMX_OFF_PTR1 : `LMX_OFF_PTR0, {16'h0000, p});
         ins(`LMX_VAL_WI | {11'h000, n, m});
         np = m[0] ? p - 16'h0001 : p + 16'h0001;
         ea = m[1] ? p : np;
         `CHK("ind we", 1'b1, we)
         `CHK("ind addr", ea, daddr)
         `CHK("ind wdata", 8'h4F, wd)
         rchk(n ? `LMX_OFF_PTR1 : `LMX_OFF_PTR0, {16'h0000, np});
      end
      wr(`LMX_OFF_PTR0, 32'h0000_0100);
      ins(`LMX_VAL_WIK | 14'h0020);
      `CHK("offset addr", 16'h00E0, daddr)
      ins(`LMX_VAL_WIK | 14'h001F);
      `CHK("offset addr", 16'h011F, daddr)
      rchk(`LMX_OFF_PTR0, 32'h0000_0100);
      rchk(`LMX_OFF_FLAGS, 32'h0000_00A5);
      $display("indirect store done");
   endtask

   task automatic t_return;
      wr(`LMX_OFF_INTC, 32'h0000_0000);
      @(posedge clk);
      stack_top <= 15'h2ABC;
      ins(`LMX_OP_RETI);
      `CHK("pop", 1'b1, pop)
      `CHK("pc", 15'h2ABC, pc)
      `CHK("gie", 1'b1, global_interrupt_enable)
      `CHK("ready", 1'b0, irdy)
      @(negedge clk);
      `CHK("ready", 1'b1, irdy)
      `CHK("pop", 1'b0, pop)
      rchk(`LMX_OFF_INTC, 32'h0000_0080);
      rchk(`LMX_OFF_FLAGS, 32'h0000_00A5);
      $display("return done");
   endtask

   task automatic t_nop;
      logic [14:0] p0;
      p0 = pc;
      ins(`LMX_OP_NOP);
      `CHK("pc", p0 + 15'h0001, pc)
      `CHK("we", 1'b0, we)
      rchk(`LMX_OFF_WREG, 32'h0000_004F);
      $display("no-op done");
   endtask

   task automatic t_swreset;
      ins(`LMX_OP_RESET);
      `CHK("reset req", 1'b1, rreq)
      @(negedge clk);
      `CHK("reset req", 1'b0, rreq)
      rchk(`LMX_OFF_PWRC, 32'h0000_0000);
      rchk(`LMX_OFF_WREG, 32'h0000_0000);
      $display("software reset done");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // The whole sequence needs a few hundred cycles; this leaves ample margin.
   initial
   begin
      #1_000_000;
      err_total++;
      $display("watchdog expired");
      finish_test;
   end

   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_literals;
      t_file_store;
      t_indirect;
      t_return;
      t_nop;
      t_swreset;
      finish_test;
   end
endmodule // lmx_exec_tb_top
`default_nettype wire
